// ===== inc/obl_pkg.sv
// Package for the option byte configuration loader: flash layout, field positions, reset defaults.
// Assumes a byte-wide program flash read port and an APB slave for status only.
package obl_pkg;
	localparam int          FLASH_AW          = 16;
	localparam logic [15:0] OPT_ADDR_BYTE0    = 16'h0000;
	localparam logic [15:0] OPT_ADDR_BYTE1    = 16'h0001;
	localparam int          OPT_BYTE_COUNT    = 2;
	// Byte 0 fields
	localparam int          B0_OSC_HI         = 7;
	localparam int          B0_OSC_LO         = 6;
	localparam int          B0_WDT_ACTION     = 5;
	localparam int          B0_WDT_START      = 4;
	localparam int          B0_BROWNOUT_STOP  = 3;
	localparam int          B0_DEBUG_DIS_N    = 2;
	localparam int          B0_FLASH_WRITE    = 1;
	localparam int          B0_CODE_READ      = 0;
	// Byte 1 fields
	localparam int          B1_MOTOR_N        = 2;
	localparam int          B1_HIGH_OFF       = 1;
	localparam int          B1_LOW_OFF        = 0;
	// Erased flash reads all ones; this is also the value held before the first load
	localparam logic [7:0]  ERASED_BYTE       = 8'hff;
	// APB map (status only; configuration itself is not reachable)
	localparam logic [7:0]  REG_LOAD_STATUS   = 8'h00;
	localparam logic [7:0]  REG_LOAD_COUNT    = 8'h04;
	localparam int          STATUS_DONE_BIT   = 0;
	localparam int          STATUS_BUSY_BIT   = 1;
	localparam logic [31:0] APB_UNMAPPED_DATA = 32'h0000_0000;
	// Flash read latency in clock cycles
	localparam int          FLASH_READ_CYCLES = 2;

	typedef enum logic [1:0] {
		OBL_IDLE,
		OBL_ISSUE,
		OBL_WAIT,
		OBL_DONE
	} obl_state_t;
endpackage

// ===== inc/obl_flash_if.sv
// Interface carrying the byte read port between loader and flash reader.
// Assumes a single clock domain.
`timescale 1ns/10ps
interface obl_flash_if;
	logic        req;
	logic [15:0] addr;
	logic        ack;
	logic [7:0]  data;
	modport loader (output req, output addr, input ack, input data);
	modport reader (input req, input addr, output ack, output data);
endinterface

// ===== rtl/obl_flash_reader.sv
// Flash byte reader: turns a request into a timed read on the flash pins.
// Assumes flash data is valid a fixed number of cycles after the address.
`timescale 1ns/10ps
module obl_flash_reader
	import obl_pkg::*;
(
	input  wire logic                i_ref_clk,
	input  wire logic                i_rst,
	obl_flash_if.reader              fl,
	output      logic [FLASH_AW-1:0] o_flash_addr,
	output      logic                o_flash_rd,
	input  wire logic [7:0]          i_flash_data
);
	typedef struct packed {
		logic [1:0]  cnt;
		logic        busy;
		logic        ack;
		logic [7:0]  data;
		logic [15:0] addr;
	} obl_rd_t;

	obl_rd_t cur;
	obl_rd_t next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.ack = 1'b0;
		if (!cur.busy && fl.req && !cur.ack) begin
			next_cur.busy = 1'b1;
			next_cur.addr = fl.addr;
			next_cur.cnt  = 2'(FLASH_READ_CYCLES - 1);
		end else if (cur.busy) begin
			if (cur.cnt == 2'h0) begin
				next_cur.busy = 1'b0;
				next_cur.ack  = 1'b1;
				next_cur.data = i_flash_data;
			end else begin
				next_cur.cnt = cur.cnt - 2'h1;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign fl.ack       = cur.ack;
	assign fl.data      = cur.data;
	assign o_flash_addr = cur.addr;
	assign o_flash_rd   = cur.busy;
endmodule

// ===== rtl/obl_config_loader.sv
// Option byte configuration loader: reads option bytes from program flash at every reset
// and latches them into hidden configuration flops. Assumes flash and consumers share i_ref_clk.
//
// What this block does
// - New option values apply only after reset
// - Load option bytes on every reset kind
// - Hold reset until configuration fully loaded
// - Configuration registers invisible to software bus
// - Options come from program bytes 0..1
// - Byte0 bits 7:6 select oscillator mode
// - Byte0 bit5: watchdog interrupt or reset
// - Byte0 bit4: watchdog auto start or instruction
// - Byte0 bit3: brownout kept during stop
// - Byte0 bit2 low disables debug serial
// - Byte0 bit1 permits user flash writes
// - Byte0 bit0 permits code reads
// - Erased flash gives safe default settings
// - Byte1 bit2 low selects motor pins
// - Byte1 bit1 sets high-side off level
// - Byte1 bit0 sets low-side off level
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module obl_config_loader
	import obl_pkg::*;
(
	input  wire logic                i_ref_clk,
	input  wire logic                i_rst,
	input  wire logic                i_short_rst,
	input  wire logic                i_stop_recover,
	output      logic [FLASH_AW-1:0] o_flash_addr,
	output      logic                o_flash_rd,
	input  wire logic [7:0]          i_flash_data,
	output      logic                o_core_rst,
	output      logic [1:0]          o_oscillator_mode_select,
	output      logic                o_watchdog_timeout_action,
	output      logic                o_watchdog_start_policy,
	output      logic                o_brownout_keep_in_stop,
	output      logic                o_debug_serial_disable_n,
	output      logic                o_flash_write_permit,
	output      logic                o_code_read_permit,
	output      logic                o_motor_pins_select_n,
	output      logic                o_high_side_off_level,
	output      logic                o_low_side_off_level,
	input  wire logic                i_psel,
	input  wire logic                i_penable,
	input  wire logic                i_pwrite,
	input  wire logic [7:0]          i_paddr,
	input  wire logic [31:0]         i_pwdata,
	output      logic [31:0]         o_prdata,
	output      logic                o_pready,
	output      logic                o_pslverr
);
	typedef struct packed {
		obl_state_t  state;
		logic        idx;
		logic        req;
		logic [7:0]  opt0;
		logic [7:0]  opt1;
		logic        core_rst;
		logic        done;
		logic [15:0] loads;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} obl_state_reg_t;

	obl_state_reg_t cur;
	obl_state_reg_t next_cur;
	obl_flash_if    fl ();

	function automatic logic [15:0] opt_addr(input logic idx);
		opt_addr = idx ? OPT_ADDR_BYTE1 : OPT_ADDR_BYTE0;
	endfunction

	obl_flash_reader u_reader (
		.i_ref_clk    (i_ref_clk),
		.i_rst        (i_rst),
		.fl           (fl),
		.o_flash_addr (o_flash_addr),
		.o_flash_rd   (o_flash_rd),
		.i_flash_data (i_flash_data)
	);

	assign fl.req  = cur.req;
	assign fl.addr = opt_addr(cur.idx);

	// Write data is ignored and every write gets pslverr: configuration is not writable
	logic unused_wdata;
	assign unused_wdata = ^i_pwdata;

	always_comb begin
		next_cur = cur;
		next_cur.pready  = 1'b0;
		next_cur.pslverr = 1'b0;
		// Short reset and stop recovery restart the load without clearing the latches
		// A restart during a read must not latch that read's late answer as byte 0,
		// so the restart parks in idle until the reader is quiet
		if (i_short_rst || i_stop_recover) begin
			next_cur.state    = OBL_IDLE;
			next_cur.idx      = 1'b0;
			next_cur.req      = 1'b0;
			next_cur.core_rst = 1'b1;
			next_cur.done     = 1'b0;
		end else begin
			case (cur.state)
				OBL_IDLE: begin
					if (!o_flash_rd && !fl.ack) begin
						next_cur.state = OBL_ISSUE;
						next_cur.req   = 1'b1;
					end
				end
				OBL_ISSUE: begin
					next_cur.req   = 1'b0;
					next_cur.state = OBL_WAIT;
				end
				OBL_WAIT: begin
					if (fl.ack) begin
						// Apart from i_rst, latches only change here, so flash writes later have no effect
						if (cur.idx) begin
							next_cur.opt1  = fl.data;
							next_cur.state = OBL_DONE;
						end else begin
							next_cur.opt0  = fl.data;
							next_cur.idx   = 1'b1;
							next_cur.req   = 1'b1;
							next_cur.state = OBL_ISSUE;
						end
					end
				end
				OBL_DONE: begin
					if (!cur.done) begin
						next_cur.done     = 1'b1;
						next_cur.core_rst = 1'b0;
						next_cur.loads    = cur.loads + 16'h0001;
					end
				end
				default: begin
					next_cur.state = OBL_IDLE;
				end
			endcase
		end
		// APB: status only; the option latches are never decoded here
		if (i_psel && i_penable && !cur.pready) begin
			next_cur.pready = 1'b1;
			next_cur.prdata = APB_UNMAPPED_DATA;
			if (i_pwrite) begin
				next_cur.pslverr = 1'b1;
			end else begin
				case (i_paddr)
					REG_LOAD_STATUS: begin
						next_cur.prdata[STATUS_DONE_BIT] = cur.done;
						next_cur.prdata[STATUS_BUSY_BIT] = cur.core_rst;
					end
					REG_LOAD_COUNT: begin
						next_cur.prdata[15:0] = cur.loads;
					end
					default: begin
						next_cur.pslverr = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cur          <= '0;
			cur.state    <= OBL_IDLE;
			cur.opt0     <= ERASED_BYTE;
			cur.opt1     <= ERASED_BYTE;
			cur.core_rst <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// Consumers see the latched bytes; byte1 reserved bits are left to the programmer
	assign o_core_rst                = cur.core_rst;
	assign o_oscillator_mode_select  = cur.opt0[B0_OSC_HI:B0_OSC_LO];
	assign o_watchdog_timeout_action = cur.opt0[B0_WDT_ACTION];
	assign o_watchdog_start_policy   = cur.opt0[B0_WDT_START];
	assign o_brownout_keep_in_stop   = cur.opt0[B0_BROWNOUT_STOP];
	assign o_debug_serial_disable_n  = cur.opt0[B0_DEBUG_DIS_N];
	assign o_flash_write_permit      = cur.opt0[B0_FLASH_WRITE];
	assign o_code_read_permit        = cur.opt0[B0_CODE_READ];
	assign o_motor_pins_select_n     = cur.opt1[B1_MOTOR_N];
	assign o_high_side_off_level     = cur.opt1[B1_HIGH_OFF];
	assign o_low_side_off_level      = cur.opt1[B1_LOW_OFF];
	assign o_prdata                  = cur.prdata;
	assign o_pready                  = cur.pready;
	assign o_pslverr                 = cur.pslverr;
endmodule

// ===== tb/obl_checker.sv
// Checker: relations over time at the loader's top-level ports.
// Assumes one clock domain and a bind onto obl_config_loader.
`timescale 1ns/10ps
module obl_checker
	import obl_pkg::*;
(
	input wire logic                i_ref_clk,
	input wire logic                i_rst,
	input wire logic                i_short_rst,
	input wire logic                i_stop_recover,
	input wire logic [FLASH_AW-1:0] o_flash_addr,
	input wire logic                o_flash_rd,
	input wire logic                o_core_rst,
	input wire logic [1:0]          o_oscillator_mode_select,
	input wire logic                o_watchdog_timeout_action,
	input wire logic                o_watchdog_start_policy,
	input wire logic                o_brownout_keep_in_stop,
	input wire logic                o_debug_serial_disable_n,
	input wire logic                o_flash_write_permit,
	input wire logic                o_code_read_permit,
	input wire logic                o_motor_pins_select_n,
	input wire logic                o_high_side_off_level,
	input wire logic                o_low_side_off_level,
	input wire logic                i_psel,
	input wire logic                i_penable,
	input wire logic                i_pwrite,
	input wire logic [31:0]         o_prdata,
	input wire logic                o_pready,
	input wire logic                o_pslverr
);
	logic [10:0] cfg;
	assign cfg = {o_oscillator_mode_select, o_watchdog_timeout_action, o_watchdog_start_policy,
		o_brownout_keep_in_stop, o_debug_serial_disable_n, o_flash_write_permit, o_code_read_permit,
		o_motor_pins_select_n, o_high_side_off_level, o_low_side_off_level};
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	AST_NO_RUN_WHILE_LOADING: assert property (!o_core_rst |-> !o_flash_rd)
		else $error("core released during a flash read");
	AST_RELEASE_BOUND: assert property ($past(i_rst) |-> ##[1:30] !o_core_rst)
		else $error("core not released after load");
	AST_RESTART_HOLDS_CORE: assert property ((i_short_rst || i_stop_recover) |-> ##[1:2] o_core_rst)
		else $error("short reset did not hold the core");
	AST_RESTART_READS: assert property ((i_short_rst || i_stop_recover)
		|-> ##[1:4] (o_flash_rd && o_flash_addr == OPT_ADDR_BYTE0))
		else $error("short reset did not start a fetch of byte 0");
	AST_OPTION_ADDR: assert property (o_flash_rd
		|-> (o_flash_addr == OPT_ADDR_BYTE0 || o_flash_addr == OPT_ADDR_BYTE1))
		else $error("fetch outside the option bytes");
	AST_ERASED_DEFAULT: assert property ($past(i_rst) |-> cfg == 11'h7ff && o_core_rst)
		else $error("reset value not all ones");
	AST_HELD_BETWEEN_LOADS: assert property (!o_core_rst && $past(!o_core_rst) |-> $stable(cfg))
		else $error("configuration changed outside a load");
	AST_WRITE_REFUSED: assert property (i_psel && i_penable && i_pwrite && o_pready |-> o_pslverr)
		else $error("write not refused");
	AST_ONE_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready)
		else $error("bus answer late");
endmodule
bind obl_config_loader obl_checker obl_checker_inst (.*);

// ===== tb/obl_flash_model.sv
// Option byte area of program flash, four bytes, erased to all ones.
// Drives the inverse of the last byte while no read is in flight.
`timescale 1ns/10ps
module obl_flash_model
	import obl_pkg::*;
(
	input  wire logic                i_ref_clk,
	input  wire logic [FLASH_AW-1:0] i_flash_addr,
	input  wire logic                i_flash_rd,
	output      logic [7:0]          o_flash_data
);
	logic [7:0] mem [4] = '{8'hff, 8'hff, 8'hff, 8'hff};
	logic [7:0] last = 8'h00;
	assign o_flash_data = i_flash_rd ? mem[i_flash_addr[1:0]] : ~last;
	always_ff @(posedge i_ref_clk) begin
		last <= o_flash_data;
	end
endmodule

// ===== tb/option_byte_config_loader_tb.sv
// Testbench: reloads of option bytes over all reset kinds, APB status access.
// Assumes the flash model and the bound checker.
`timescale 1ns/10ps
module option_byte_config_loader_tb;
	import obl_pkg::*;
	logic clk = 0, rst = 1, srst = 0, stop = 0, psel = 0, pen = 0, pwr = 0;
	logic [7:0] paddr = 8'h00, fdata;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [15:0] faddr;
	logic frd, core, pready, pslverr, wta, wsp, bks, dbg, flash_write_permit, crp, mot, hi, lo;
	logic [1:0] osc;
	logic [7:0] b0, b1;
	int miscompares = 0, n_tests = 0;
	initial forever #25 clk = ~clk;
	obl_config_loader obl_config_loader_inst (.i_ref_clk(clk), .i_rst(rst), .i_short_rst(srst),
		.i_stop_recover(stop), .o_flash_addr(faddr), .o_flash_rd(frd), .i_flash_data(fdata),
		.o_core_rst(core), .o_oscillator_mode_select(osc), .o_watchdog_timeout_action(wta),
		.o_watchdog_start_policy(wsp), .o_brownout_keep_in_stop(bks), .o_debug_serial_disable_n(dbg),
		.o_flash_write_permit(flash_write_permit), .o_code_read_permit(crp), .o_motor_pins_select_n(mot),
		.o_high_side_off_level(hi), .o_low_side_off_level(lo), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr));
	obl_flash_model obl_flash_model_inst (.i_ref_clk(clk), .i_flash_addr(faddr), .i_flash_rd(frd),
		.o_flash_data(fdata));
	task tally_and_finish;
		if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] exp, input logic experr);
		int i;
		@(posedge clk);
		psel <= 1; pwr <= wr; paddr <= a; pwdata <= 32'h0000_00a5;
		@(posedge clk);
		pen <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin miscompares++; tally_and_finish(); end
		if (!wr) chk("prdata", prdata, exp);
		chk("pslverr", {31'h0, pslverr}, {31'h0, experr});
		psel <= 0; pen <= 0;
	endtask
	task wait_load;
		int i;
		for (i = 0; i < 100; i++) begin
			@(posedge clk); #1;
			if (core === 1'b0) break;
		end
		if (i == 100) begin miscompares++; tally_and_finish(); end
	endtask
	task chk_cfg(input logic [7:0] e0, input logic [7:0] e1);
		chk("byte0", {24'h0, osc, wta, wsp, bks, dbg, flash_write_permit, crp}, {24'h0, e0});
		chk("byte1", {29'h0, mot, hi, lo}, {29'h0, e1[2:0]});
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		wait_load();
		chk_cfg(8'hff, 8'hff);
		apb(0, REG_LOAD_STATUS, 32'h0000_0001, 0);
		apb(0, REG_LOAD_COUNT, 32'h0000_0001, 0);
		// New option contents must wait for a reset; writes cannot reach the latches
		obl_flash_model_inst.mem[0] = 8'h00;
		obl_flash_model_inst.mem[1] = 8'hf8;
		apb(1, REG_LOAD_STATUS, 32'h0, 1);
		apb(0, 8'h08, APB_UNMAPPED_DATA, 1);
		repeat (10) @(posedge clk);
		chk_cfg(8'hff, 8'hff);
		for (int k = 0; k < 4; k++) begin
			b0 = {k[1:0], k[0] ? 6'h15 : 6'h2a};
			b1 = {5'h1f, k[0] ? 3'h5 : 3'h2};
			obl_flash_model_inst.mem[0] = b0;
			obl_flash_model_inst.mem[1] = b1;
			@(posedge clk);
			if (k[0]) stop <= 1;
			else srst <= 1;
			@(posedge clk);
			stop <= 0; srst <= 0;
			@(posedge clk); #1;
			chk("core_rst", {31'h0, core}, 32'h1);
			wait_load();
			chk_cfg(b0, b1);
			apb(0, REG_LOAD_COUNT, k + 2, 0);
		end
		tally_and_finish();
	end
endmodule
